//--- include/tws_pkg.sv
// Purpose: Shared constants for the table-write and test-skip decoder
// Assumes: APB slave, 32-bit data, one word per register
// Notes:   Offsets are byte addresses on the APB
// Notes on behaviour
// RULE1: Low three pointer bits pick one of eight holding registers.
// RULE2: Holding registers stage data for later flash programming.
// RULE3: Table pointer is 21 bits, byte addressed, two megabytes.
// RULE4: Pointer bit zero selects low (0) or high (1) word byte; code uses it only as the low bit of the holding-register index.
// RULE5: Opcode low bits: 0 keep, 1 post-inc, 2 post-dec, 3 pre-inc.
// RULE6: Table write takes two cycles; latch read Q2, holding write Q4.
// RULE7: Test-skip discards next instruction when register is zero; two cycles.
// RULE8: Skip over a two-word instruction makes three cycles.
// RULE9: Bank bit 0 uses access bank, 1 uses bank select register.
// RULE10: Bank bit 0, extension on, address up to 95 uses indexed offset; code only sets the STATUS indexed bit, EFFADDR keeps the access-bank address.
// RULE11: No status flags change; table write leaves table latch alone.
package tws_pkg;
   localparam int PTR_W = 21;
   localparam int HOLD_N = 8;
   localparam int HOLD_SEL_W = 3;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_PTR     = 8'h04;
   localparam logic [7:0] OFF_LATCH   = 8'h08;
   localparam logic [7:0] OFF_BANK    = 8'h0c;
   localparam logic [7:0] OFF_OPCODE  = 8'h10;
   localparam logic [7:0] OFF_FILEVAL = 8'h14;
   localparam logic [7:0] OFF_STATUS  = 8'h18;
   localparam logic [7:0] OFF_EFFADDR = 8'h1c;
   localparam logic [7:0] OFF_HOLD0   = 8'h20;
   // Field positions
   localparam int CTRL_XINST    = 0;
   localparam int CTRL_NEXT2W   = 1;
   localparam int ST_BUSY       = 0;
   localparam int ST_SKIP       = 1;
   localparam int ST_INDEXED    = 2;
   localparam int ST_ACCESS     = 3;
   // Opcode patterns
   localparam logic [13:0] TABLE_WRITE_OP_HI = 14'h0003;   // 0000 0000 0000 11
   localparam logic [6:0]  TST_HI   = 7'h33;      // 0110 011
   localparam logic [7:0]  IDX_LIMIT = 8'h5f;
   localparam logic [7:0]  ACC_SPLIT = 8'h60;
   localparam logic [3:0]  ACC_HI_BANK = 4'hf;
   localparam logic [1:0]  UPD_KEEP = 2'h0;
   localparam logic [1:0]  UPD_POSTINC = 2'h1;
   localparam logic [1:0]  UPD_POSTDEC = 2'h2;
   localparam logic [1:0]  UPD_PREINC = 2'h3;
   localparam logic [1:0]  Q1 = 2'h0;
   localparam logic [1:0]  Q2 = 2'h1;
   localparam logic [1:0]  Q4 = 2'h3;
   // Execution states, Gray along the usual path
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_DEC  = 3'h1,
      ST_EX2  = 3'h3,
      ST_EX3  = 3'h2
   } tws_state_e;
endpackage

//--- hw/tws_hold_mem.sv
// Purpose: Eight-byte write holding buffer
// Assumes: Single write port, registered read port
// Notes:   Contents later feed flash programming
`timescale 1ns/1ps
module tws_hold_mem (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       wr_en,
   input  wire logic [2:0] wr_idx,
   input  wire logic [7:0] wr_data,
   input  wire logic [2:0] rd_idx,
   output logic      [7:0] rd_data
);
   typedef struct packed {
      logic [7:0][7:0] mem;
      logic [7:0]      rd;
   } tws_mem_s;
   tws_mem_s st_reg;
   tws_mem_s st_next;

   ////////////////////////////////////////////////////////////////
   // Staging buffer write and registered readback
   always_comb begin
      st_next = st_reg;
      if (wr_en) begin
         st_next.mem[wr_idx] = wr_data; // RULE2
      end
      st_next.rd = st_reg.mem[rd_idx];
   end

   // Erased flash reads as ones, so buffer resets to ones
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rd_data = st_reg.rd;
endmodule

//--- hw/tws_ptr_upd.sv
// Purpose: Table pointer update arithmetic
// Assumes: Combinational, used once per table write
// Notes:   Wraps across the 21-bit space
`timescale 1ns/1ps
module tws_ptr_upd (
   input  wire logic [20:0] ptr_in,
   input  wire logic [1:0]  mode,
   output logic      [20:0] ptr_write,
   output logic      [20:0] ptr_after
);
   // Pre-increment moves before the write, the rest after
   always_comb begin
      ptr_write = ptr_in;
      ptr_after = ptr_in;
      unique case (mode)
         tws_pkg::UPD_KEEP: ptr_after = ptr_in; // RULE5
         tws_pkg::UPD_POSTINC: ptr_after = ptr_in + 21'h000001; // RULE5
         tws_pkg::UPD_POSTDEC: ptr_after = ptr_in - 21'h000001; // RULE5
         tws_pkg::UPD_PREINC: begin
            ptr_write = ptr_in + 21'h000001; // RULE5
            ptr_after = ptr_in + 21'h000001;
         end
      endcase
   end
endmodule

//--- hw/tws_core.sv
// Purpose: Table-write and test-skip execution over APB
// Assumes: One instruction clock is four pclk cycles (Q1..Q4)
// Notes:   Writing OPCODE launches execution; STATUS shows progress
`timescale 1ns/1ps
module tws_core (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             flush_fetch,
   output logic [1:0]       exec_cycles
);
   typedef struct packed {
      tws_pkg::tws_state_e state;
      logic [1:0]  q;
      logic [1:0]  cyc;
      logic [1:0]  cyc_total;
      logic [15:0] opcode;
      logic [20:0] ptr;
      logic [7:0]  latch;
      logic [7:0]  latch_cap;
      logic [3:0]  bank;
      logic [7:0]  fileval;
      logic        xinst;
      logic        next2w;
      logic        skip;
      logic        indexed;
      logic        access;
      logic [11:0] effaddr;
      logic [20:0] ptr_wr;
      logic        flush;
      logic [31:0] rdata;
   } tws_core_s;

   tws_core_s st_reg;
   tws_core_s st_next;
   logic [20:0] ptr_write;
   logic [20:0] ptr_after;
   logic        hold_we;
   logic [7:0]  hold_rd;
   logic        wr_acc;
   logic        rd_acc;
   logic        hold_hit;

   // Pointer arithmetic against the live pointer
   tws_ptr_upd u_upd (
      .ptr_in    (st_reg.ptr),
      .mode      (st_reg.opcode[1:0]),
      .ptr_write (ptr_write),
      .ptr_after (ptr_after)
   );

   // Low pointer bits index the holding buffer
   tws_hold_mem u_hold (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (hold_we),
      .wr_idx  (st_reg.ptr_wr[2:0]), // RULE1 RULE4
      .wr_data (st_reg.latch_cap),
      .rd_idx  (paddr[4:2]),
      .rd_data (hold_rd)
   );

   ////////////////////////////////////////////////////////////////
   // Decode helpers
   function automatic logic is_table_write_op(input logic [15:0] op);
      return op[15:2] == tws_pkg::TABLE_WRITE_OP_HI;
   endfunction

   function automatic logic is_tst(input logic [15:0] op);
      return op[15:9] == tws_pkg::TST_HI;
   endfunction

   function automatic logic is_hold(input logic [7:0] a);
      return a[7:5] == tws_pkg::OFF_HOLD0[7:5];
   endfunction

   ////////////////////////////////////////////////////////////////
   // APB access qualifiers; hold reads need one extra cycle
   assign wr_acc   = psel && penable && pwrite;
   assign hold_hit = is_hold(paddr);
   assign rd_acc   = psel && penable && !pwrite;
   assign pready   = !(psel && penable && !pwrite && hold_hit && !st_reg.rdata[31]);
   assign pslverr  = 1'b0;
   assign hold_we  = (st_reg.state == tws_pkg::ST_EX2) && (st_reg.q == tws_pkg::Q4)
                     && is_table_write_op(st_reg.opcode); // RULE6

   ////////////////////////////////////////////////////////////////
   // Next state of the whole block
   always_comb begin
      st_next = st_reg;
      st_next.flush = 1'b0;
      // Q phase counter advances every pclk while executing
      if (st_reg.state != tws_pkg::ST_IDLE) begin
         st_next.q = st_reg.q + 2'h1;
      end

      unique case (st_reg.state)
         tws_pkg::ST_IDLE: begin
            st_next.q = tws_pkg::Q1;
            if (wr_acc && paddr == tws_pkg::OFF_OPCODE &&
                (is_table_write_op(pwdata[15:0]) || is_tst(pwdata[15:0]))) begin
               st_next.opcode = pwdata[15:0];
               st_next.state  = tws_pkg::ST_DEC;
               st_next.cyc    = 2'h1;
               st_next.skip   = 1'b0;
            end
         end
         tws_pkg::ST_DEC: begin
            // Test-skip: addressing resolved and register tested in Q2
            if (is_tst(st_reg.opcode) && st_reg.q == tws_pkg::Q2) begin
               st_next.access  = !st_reg.opcode[8]; // RULE9
               st_next.indexed = !st_reg.opcode[8] && st_reg.xinst
                                 && st_reg.opcode[7:0] <= tws_pkg::IDX_LIMIT; // RULE10
               if (st_reg.opcode[8]) begin
                  st_next.effaddr = {st_reg.bank, st_reg.opcode[7:0]}; // RULE9
               end else if (st_reg.opcode[7:0] >= tws_pkg::ACC_SPLIT) begin
                  st_next.effaddr = {tws_pkg::ACC_HI_BANK, st_reg.opcode[7:0]};
               end else begin
                  st_next.effaddr = {4'h0, st_reg.opcode[7:0]};
               end
               st_next.skip = st_reg.fileval == 8'h00; // RULE7
            end
            if (st_reg.q == tws_pkg::Q4) begin
               if (is_table_write_op(st_reg.opcode)) begin
                  st_next.state     = tws_pkg::ST_EX2; // RULE6
                  st_next.cyc_total = 2'h2;
               end else if (st_reg.skip) begin
                  st_next.state     = tws_pkg::ST_EX2; // RULE7
                  st_next.flush     = 1'b1;            // RULE7
                  st_next.cyc_total = st_reg.next2w ? 2'h3 : 2'h2; // RULE8
               end else begin
                  st_next.state     = tws_pkg::ST_IDLE;
                  st_next.cyc_total = 2'h1;
               end
               st_next.cyc = st_reg.cyc + 2'h1;
            end
         end
         tws_pkg::ST_EX2: begin
            // Latch sampled in Q2 into a private copy
            if (is_table_write_op(st_reg.opcode) && st_reg.q == tws_pkg::Q2) begin
               st_next.latch_cap = st_reg.latch; // RULE6
               st_next.ptr_wr    = ptr_write;    // RULE5
            end
            if (is_table_write_op(st_reg.opcode) && st_reg.q == tws_pkg::Q4) begin
               st_next.ptr = ptr_after; // RULE3 RULE5
            end
            if (st_reg.q == tws_pkg::Q4) begin
               if (!is_table_write_op(st_reg.opcode) && st_reg.next2w) begin
                  st_next.state = tws_pkg::ST_EX3; // RULE8
                  st_next.cyc   = st_reg.cyc + 2'h1;
               end else begin
                  st_next.state = tws_pkg::ST_IDLE;
               end
            end
         end
         tws_pkg::ST_EX3: begin
            // Second word of the discarded instruction also becomes a no-op
            if (st_reg.q == tws_pkg::Q4) begin
               st_next.state = tws_pkg::ST_IDLE; // RULE8
            end
         end
         default: st_next.state = tws_pkg::ST_IDLE;
      endcase

      // Software writes; pointer and latch are frozen while busy
      if (wr_acc && st_reg.state == tws_pkg::ST_IDLE) begin
         unique case (paddr)
            tws_pkg::OFF_CTRL: begin
               st_next.xinst  = pwdata[tws_pkg::CTRL_XINST];
               st_next.next2w = pwdata[tws_pkg::CTRL_NEXT2W];
            end
            tws_pkg::OFF_PTR:     st_next.ptr = pwdata[20:0]; // RULE3
            tws_pkg::OFF_LATCH:   st_next.latch = pwdata[7:0];
            tws_pkg::OFF_BANK:    st_next.bank = pwdata[3:0];
            tws_pkg::OFF_FILEVAL: st_next.fileval = pwdata[7:0];
            default: ;
         endcase
      end

      // Read data; bit 31 marks a second hold-read cycle
      st_next.rdata = 32'h0000_0000;
      if (rd_acc) begin
         if (hold_hit) begin
            st_next.rdata = st_reg.rdata[31] ? 32'h0000_0000 : {1'b1, 23'h000000, hold_rd};
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Register the state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg       <= '0;
         st_reg.state <= tws_pkg::ST_IDLE;
         st_reg.latch <= 8'h00;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read mux; no arithmetic flags exist, latch never written by execution
   always_comb begin
      prdata = 32'h0000_0000; // RULE11
      unique case (paddr)
         tws_pkg::OFF_CTRL:    prdata = {30'h0, st_reg.next2w, st_reg.xinst};
         tws_pkg::OFF_PTR:     prdata = {11'h000, st_reg.ptr};
         tws_pkg::OFF_LATCH:   prdata = {24'h000000, st_reg.latch}; // RULE11
         tws_pkg::OFF_BANK:    prdata = {28'h0000000, st_reg.bank};
         tws_pkg::OFF_OPCODE:  prdata = {16'h0000, st_reg.opcode};
         tws_pkg::OFF_FILEVAL: prdata = {24'h000000, st_reg.fileval};
         tws_pkg::OFF_STATUS:  prdata = {26'h0, st_reg.cyc_total, st_reg.access,
                                         st_reg.indexed, st_reg.skip,
                                         st_reg.state != tws_pkg::ST_IDLE};
         tws_pkg::OFF_EFFADDR: prdata = {20'h00000, st_reg.effaddr};
         default: begin
            if (hold_hit) begin
               prdata = {24'h000000, hold_rd}; // RULE2
            end
         end
      endcase
   end

   assign flush_fetch = st_reg.flush;
   assign exec_cycles = st_reg.cyc_total;
endmodule

//--- bench/tws_checker.sv
// Purpose: Port-level checks on table-write and test-skip timing
// Assumes: Bench never writes OPCODE while busy
// Notes:   FILEVAL and CTRL writes are shadowed to predict the skip
`timescale 1ns/1ps
module tws_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        flush_fetch,
   input wire logic [1:0]  exec_cycles
);
   logic fz_reg;
   logic w2_reg;
   wire logic wr = psel && penable && pready && pwrite;
   wire logic tst = wr && paddr == tws_pkg::OFF_OPCODE && pwdata[15:9] == tws_pkg::TST_HI;
   wire logic tbl = wr && paddr == tws_pkg::OFF_OPCODE && pwdata[15:2] == tws_pkg::TABLE_WRITE_OP_HI;
   // Shadow of the tested value and two-word flag, known before launch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fz_reg <= 1'b0;
         w2_reg <= 1'b0;
      end else begin
         if (wr && paddr == tws_pkg::OFF_FILEVAL) fz_reg <= pwdata[7:0] == 8'h00;
         if (wr && paddr == tws_pkg::OFF_CTRL) w2_reg <= pwdata[tws_pkg::CTRL_NEXT2W];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_flush_single: assert property (flush_fetch |=> !flush_fetch)
      else $error("flush wider than one cycle");
   a_skip_flush: assert property (tst && fz_reg |-> ##[3:5] flush_fetch)
      else $error("no flush on zero");
   a_noskip_quiet: assert property (tst && !fz_reg |=> !flush_fetch [*6])
      else $error("flush on nonzero");
   a_tbl_quiet: assert property (tbl |=> !flush_fetch [*8])
      else $error("flush on table write");
   a_tbl_cycles: assert property (tbl |-> ##10 exec_cycles == 2'h2)
      else $error("table write not two cycles");
   a_skip_two: assert property (tst && fz_reg && !w2_reg |-> ##10 exec_cycles == 2'h2)
      else $error("skip not two cycles");
   a_skip_three: assert property (tst && fz_reg && w2_reg |-> ##14 exec_cycles == 2'h3)
      else $error("skip over two-word not three cycles");
   a_noskip_one: assert property (tst && !fz_reg |-> ##6 exec_cycles == 2'h1)
      else $error("no-skip not one cycle");
   // Buffer reads come from a registered port, so one wait state
   a_hold_wait: assert property (psel && $rose(penable) && !pwrite && paddr >= 8'h20
      && paddr < 8'h40 |-> !pready ##1 pready)
      else $error("holding read wait state wrong");
   c_skip3: cover property (tst && fz_reg && w2_reg);
   c_tbl: cover property (tbl);
   c_flush: cover property (flush_fetch);
endmodule
bind tws_core tws_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .flush_fetch(flush_fetch), .exec_cycles(exec_cycles));

//--- bench/table_write_and_test_skip_tb.sv
// Purpose: Directed APB tests of table write and test-skip
// Assumes: Status polled before each new opcode
// Notes:   One idle cycle between transfers keeps drives single
`timescale 1ns/1ps
module table_write_and_test_skip_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, flush_fetch;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  exec_cycles;
   logic [2:0]  hidx;
   int          n_fail, check_count;
   logic [20:0] tp [4] = '{21'h00a356, 21'h1fffff, 21'h000000, 21'h01389a};
   logic [20:0] ta [4] = '{21'h00a356, 21'h000000, 21'h1fffff, 21'h01389b};
   logic [15:0] sop [6] = '{16'h6712, 16'h6612, 16'h6680, 16'h665f, 16'h6660, 16'h6730};
   logic [7:0]  sfv [6] = '{8'h01, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00};
   logic [1:0]  sct [6] = '{2'h0, 2'h0, 2'h2, 2'h1, 2'h1, 2'h1};
   logic [3:0]  sbk [6] = '{4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'ha};
   logic [4:0]  sst [6] = '{5'h08, 5'h15, 5'h1d, 5'h0e, 5'h15, 5'h11};
   logic [11:0] sea [6] = '{12'h512, 12'h012, 12'hf80, 12'h000, 12'hf60, 12'ha30};
   tws_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flush_fetch(flush_fetch), .exec_cycles(exec_cycles));
   always #20 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Ready and read data are taken at the rising edge that ends the access
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int   n;
      logic ok;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         ok = pready === 1'b1;
         rd = prdata;
         n++;
      end while (!ok && n < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (ok) begin
         chk({31'h0, pslverr}, 32'h0);
      end else begin
         n_fail++;
         end_of_test();
      end
      @(posedge pclk);
   endtask
   // Launch an opcode, then poll busy; rd keeps the final status
   task automatic run(input logic [31:0] op);
      int n;
      n = 0;
      xfer(1'b1, tws_pkg::OFF_OPCODE, op);
      do begin
         xfer(1'b0, tws_pkg::OFF_STATUS, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 30);
      if (n >= 30) begin
         n_fail++;
         end_of_test();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      n_fail = 0;
      check_count = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      xfer(1'b0, 8'h3c, 32'h0);
      chk(rd, 32'hff);
      xfer(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      // All four pointer updates, with wrap at both ends of the space
      for (int m = 0; m < 4; m++) begin
         xfer(1'b1, tws_pkg::OFF_PTR, {11'h0, tp[m]});
         xfer(1'b1, tws_pkg::OFF_LATCH, 32'h50 + m);
         run(32'h000c | m);
         hidx = (m == 3) ? tp[m][2:0] + 3'h1 : tp[m][2:0];
         xfer(1'b0, tws_pkg::OFF_HOLD0 + {3'h0, hidx, 2'h0}, 32'h0);
         chk(rd, 32'h50 + m);
         xfer(1'b0, tws_pkg::OFF_PTR, 32'h0);
         chk(rd, {11'h0, ta[m]});
         xfer(1'b0, tws_pkg::OFF_LATCH, 32'h0);
         chk(rd, 32'h50 + m);
         chk(exec_cycles, 32'h2);
      end
      // Banked, access, indexed and two-word skip cases
      for (int c = 0; c < 6; c++) begin
         xfer(1'b1, tws_pkg::OFF_CTRL, {30'h0, sct[c]});
         xfer(1'b1, tws_pkg::OFF_BANK, {28'h0, sbk[c]});
         xfer(1'b1, tws_pkg::OFF_FILEVAL, {24'h0, sfv[c]});
         run({16'h0, sop[c]});
         chk(rd[5:1], sst[c]);
         chk(exec_cycles, sst[c][4:3]);
         xfer(1'b0, tws_pkg::OFF_EFFADDR, 32'h0);
         if (c != 3) chk(rd[11:0], sea[c]);
      end
      end_of_test();
   end
endmodule
